// ==== include/sflash_read_regs.vh ====
`ifndef SFLASH_READ_REGS_VH
`define SFLASH_READ_REGS_VH

// ----------------------------------------
// command framing
// ----------------------------------------
`define OPC_BITS        7'h08
`define ADDR_END        7'h20
`define MAIN_DUMMY_END  7'h40
`define BUF_DUMMY_END   7'h28

// ----------------------------------------
// opcodes, low seven bits; bit 7 picks the spi-mode timing category
// ----------------------------------------
`define OPC_CAT_BIT     7
`define OPC_CONT_READ   7'h68
`define OPC_PAGE_READ   7'h52
`define OPC_BUF1_READ   7'h54
`define OPC_BUF2_READ   7'h56
`define OPC_STAT_READ   7'h57

// ----------------------------------------
// array geometry and address field layout
// ----------------------------------------
`define PAGE_W          12
`define BYTE_W          10
`define LAST_BYTE       10'h20F
`define PAGE_MSB        21
`define PAGE_LSB        10
`define BYTE_MSB        9
`define BUF_WORDS       1056
`define BUF2_BASE       11'h210

// ----------------------------------------
// status byte layout
// ----------------------------------------
`define STAT_READY_BIT  7
`define STAT_COMP_BIT   6
`define STAT_DENS_MSB   5
`define STAT_DENS_LSB   2
`define STAT_RSVD_VAL   2'h0

// ----------------------------------------
// buffering
// ----------------------------------------
`define FIFO_DEPTH      8
`define FIFO_AW         3

`endif

// ==== hdl/sflash_read_front.v ====
`timescale 1ns/10ps
`include "sflash_read_regs.vh"

// ----------------------------------------
// byte fifo between array fetch and serializer
// ----------------------------------------
module sflash_byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = `FIFO_AW
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             flush_i,    // drop all contents
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];  // storage words
  reg [AW-1:0]    wr_q;               // write pointer
  reg [AW-1:0]    rd_q;               // read pointer
  reg [AW:0]      cnt_q;              // fill level
  wire            push;
  wire            pop;

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // pointers wrap naturally; depth is a power of two
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // storage has no reset; only written words are ever read
  always @(posedge clk_i) begin
    if (push & ~flush_i) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule

// ----------------------------------------
// serial read front end
// ----------------------------------------
module sflash_read_front #(
  parameter [3:0] DENSITY_CODE = 4'h5   // arbitrary value
) (
  // clock and reset
  input  wire                 CLK_I,
  input  wire                 RST_I,
  // serial link pins
  input  wire                 CS_N_I,
  input  wire                 SCK_I,
  input  wire                 SI_I,
  output wire                 SO_O,
  output wire                 SO_OE_O,
  // main memory read port, data one cycle after strobe
  output wire                 MEM_RD_O,
  output wire [`PAGE_W-1:0]   MEM_PAGE_O,
  output wire [`BYTE_W-1:0]   MEM_BYTE_O,
  input  wire [7:0]           MEM_RDATA_I,
  // buffer load port from the write logic
  input  wire                 BUF_WR_I,
  input  wire                 BUF_SEL_I,
  input  wire [`BYTE_W-1:0]   BUF_ADDR_I,
  input  wire [7:0]           BUF_WDATA_I,
  // device status
  input  wire                 BUSY_I,
  input  wire                 COMP_MISMATCH_I
);
  // ----------------------------------------
  // states and command kinds
  // ----------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;  // deselected
  localparam [2:0] ST_OPC   = 3'h1;  // opcode shifting
  localparam [2:0] ST_ADDR  = 3'h2;  // address shifting
  localparam [2:0] ST_DUMMY = 3'h3;  // dummy bits
  localparam [2:0] ST_DATA  = 3'h4;  // output streaming
  localparam [2:0] ST_SKIP  = 3'h5;  // unknown opcode, ignored

  localparam [2:0] CMD_CONT = 3'h0;
  localparam [2:0] CMD_PAGE = 3'h1;
  localparam [2:0] CMD_BUF1 = 3'h2;
  localparam [2:0] CMD_BUF2 = 3'h3;
  localparam [2:0] CMD_STAT = 3'h4;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [2:0] cs_s_q;    // select sync chain
  reg [2:0] sck_s_q;   // clock sync chain
  reg [2:0] si_s_q;    // data sync chain
  reg       cs_f_q;    // filtered select, high is deselected
  reg       sck_f_q;   // filtered clock level
  wire      cs_fall;
  wire      cs_rise;
  wire      sck_rise;
  wire      sck_fall;
  wire      si_bit;

  // three stages; a change counts once stages two and three agree
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cs_s_q  <= 3'h7;
      sck_s_q <= 3'h0;
      si_s_q  <= 3'h0;
      cs_f_q  <= 1'b1;
      sck_f_q <= 1'b0;
    end else begin
      cs_s_q  <= {cs_s_q[1:0], CS_N_I};
      sck_s_q <= {sck_s_q[1:0], SCK_I};
      si_s_q  <= {si_s_q[1:0], SI_I};
      if (cs_s_q[1] == cs_s_q[2]) begin
        cs_f_q <= cs_s_q[2];
      end
      if (sck_s_q[1] == sck_s_q[2]) begin
        sck_f_q <= sck_s_q[2];
      end
    end
  end

  assign cs_fall  = cs_f_q & (cs_s_q[1] == cs_s_q[2]) & ~cs_s_q[2];
  assign cs_rise  = ~cs_f_q & (cs_s_q[1] == cs_s_q[2]) & cs_s_q[2];
  // clock edges only count while selected, so idle level is free
  assign sck_rise = ~cs_f_q & ~sck_f_q & (sck_s_q[1] == sck_s_q[2]) & sck_s_q[2];
  assign sck_fall = ~cs_f_q & sck_f_q & (sck_s_q[1] == sck_s_q[2]) & ~sck_s_q[2];
  // si is settled long before the sampling edge, stage three is safe
  assign si_bit   = si_s_q[2];

  // ----------------------------------------
  // command decoder state
  // ----------------------------------------
  reg [2:0]         st_q;        // frame state
  reg [6:0]         cnt_q;       // bits since select fell
  reg [23:0]        sr_q;        // input shift register
  reg [2:0]         cmd_q;       // decoded command
  reg               cat_spi_q;   // output timing category
  reg [`PAGE_W-1:0] page_q;      // fetch page
  reg [`BYTE_W-1:0] byte_q;      // fetch byte
  reg               fetch_en_q;  // prefetch running
  reg               pend_q;      // fetch reply due this cycle
  reg               pend_buf_q;  // reply comes from a buffer
  reg [7:0]         sh_q;        // output byte shifter
  reg [2:0]         left_q;      // bits left in shifter
  reg               so_q;        // output bit
  reg               oe_q;        // output enable
  wire [6:0]        cnt_nx;
  wire [23:0]       sr_nx;
  wire [6:0]        dummy_end;
  wire              is_buf;
  wire              adv;
  wire              f_in_ready;
  wire              f_out_valid;
  wire [7:0]        f_out_data;
  wire              f_pop;
  wire [7:0]        stat_byte;
  wire [7:0]        next_byte;
  wire              issue;

  assign cnt_nx    = cnt_q + 7'h01;
  assign sr_nx     = {sr_q[22:0], si_bit};
  assign is_buf    = (cmd_q == CMD_BUF1) | (cmd_q == CMD_BUF2);
  assign dummy_end = is_buf ? `BUF_DUMMY_END : `MAIN_DUMMY_END;
  assign adv = (st_q == ST_DATA) & (cat_spi_q ? sck_fall : sck_rise);
  assign stat_byte = {~BUSY_I, COMP_MISMATCH_I, DENSITY_CODE, `STAT_RSVD_VAL};
  assign next_byte = (cmd_q == CMD_STAT) ? stat_byte : f_out_data;
  assign f_pop     = adv & (left_q == 3'h0) & (cmd_q != CMD_STAT);
  assign issue     = fetch_en_q & f_in_ready & ~pend_q;

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q      <= ST_IDLE;
      cnt_q     <= 7'h00;
      sr_q      <= 24'h000000;
      cmd_q     <= CMD_CONT;
      cat_spi_q <= 1'b0;
    end else if (cs_rise) begin
      st_q <= ST_IDLE;
    end else if (cs_fall) begin
      st_q  <= ST_OPC;
      cnt_q <= 7'h00;
    end else if (sck_rise) begin
      // rising edge samples, any idle level
      case (st_q)
        ST_OPC: begin
          cnt_q <= cnt_nx;
          sr_q  <= sr_nx;
          if (cnt_nx == `OPC_BITS) begin
            st_q      <= ST_ADDR;
            cat_spi_q <= sr_q[`OPC_CAT_BIT-1];
            case (sr_nx[6:0])
              `OPC_CONT_READ: cmd_q <= CMD_CONT;
              `OPC_PAGE_READ: cmd_q <= CMD_PAGE;
              `OPC_BUF1_READ: cmd_q <= CMD_BUF1;
              `OPC_BUF2_READ: cmd_q <= CMD_BUF2;
              `OPC_STAT_READ: cmd_q <= CMD_STAT;
              default:        st_q  <= ST_SKIP;
            endcase
            if (sr_nx[6:0] == `OPC_STAT_READ) begin
              st_q <= ST_DATA;
            end
          end
        end
        ST_ADDR: begin
          cnt_q <= cnt_nx;
          sr_q  <= sr_nx;
          if (cnt_nx == `ADDR_END) begin
            st_q <= ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          cnt_q <= cnt_nx;
          if (cnt_nx == dummy_end) begin
            st_q <= ST_DATA;
          end
        end
        default: begin
          // data and skip ignore input bits
          st_q <= st_q;
        end
      endcase
    end
  end

  // ----------------------------------------
  // prefetch from array or buffer into the fifo
  // ----------------------------------------
  reg [7:0] buf_q [0:`BUF_WORDS-1];  // second buffer from word 528; offsets above 527 stray
  reg [7:0] buf_rd_q;                // registered buffer read
  // only the load port writes buffers
  always @(posedge CLK_I) begin
    if (BUF_WR_I) begin
      buf_q[{1'b0, BUF_ADDR_I} + (BUF_SEL_I ? `BUF2_BASE : 11'h000)] <= BUF_WDATA_I;
    end
    buf_rd_q <= buf_q[{1'b0, byte_q} + ((cmd_q == CMD_BUF2) ? `BUF2_BASE : 11'h000)];
  end

  // one fetch in flight keeps fifo overflow impossible
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      page_q     <= {`PAGE_W{1'b0}};
      byte_q     <= {`BYTE_W{1'b0}};
      fetch_en_q <= 1'b0;
      pend_q     <= 1'b0;
      pend_buf_q <= 1'b0;
    end else if (cs_rise | cs_fall) begin
      fetch_en_q <= 1'b0;
      pend_q     <= 1'b0;
    end else begin
      pend_q     <= issue;
      pend_buf_q <= is_buf;
      if (sck_rise & (st_q == ST_ADDR) & (cnt_nx == `ADDR_END)) begin
        page_q     <= sr_nx[`PAGE_MSB:`PAGE_LSB];
        byte_q     <= sr_nx[`BYTE_MSB:0];
        fetch_en_q <= 1'b1;
      end else if (issue) begin
        if (byte_q >= `LAST_BYTE) begin
          byte_q <= {`BYTE_W{1'b0}};
          if (cmd_q == CMD_CONT) begin
            page_q <= page_q + 1'b1;
          end
        end else begin
          byte_q <= byte_q + 1'b1;
        end
      end
    end
  end
  assign MEM_RD_O   = issue & ~is_buf;
  assign MEM_PAGE_O = page_q;
  assign MEM_BYTE_O = byte_q;
  sflash_byte_fifo #(
    .WIDTH (8),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .flush_i     (cs_rise | cs_fall),
    .in_valid_i  (pend_q),
    .in_ready_o  (f_in_ready),
    .in_data_i   (pend_buf_q ? buf_rd_q : MEM_RDATA_I),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_pop),
    .out_data_o  (f_out_data)
  );

  // ----------------------------------------
  // output serializer
  // ----------------------------------------
  // one bit per clock
  // an empty fifo would send a zero then seven stale storage bits; prefetch margin makes it unreachable
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sh_q   <= 8'h00;
      left_q <= 3'h0;
      so_q   <= 1'b0;
      oe_q   <= 1'b0;
    end else if (cs_rise | cs_fall) begin
      left_q <= 3'h0;
      so_q   <= 1'b0;
      oe_q   <= 1'b0;
    end else if (adv) begin
      oe_q <= 1'b1;
      if (left_q == 3'h0) begin
        so_q   <= (f_out_valid | (cmd_q == CMD_STAT)) ? next_byte[7] : 1'b0;
        sh_q   <= {next_byte[6:0], 1'b0};
        left_q <= 3'h7;
      end else begin
        so_q   <= sh_q[7];
        sh_q   <= {sh_q[6:0], 1'b0};
        left_q <= left_q - 3'h1;
      end
    end
  end

  assign SO_O    = so_q;
  assign SO_OE_O = oe_q;
endmodule

// ==== tb/sflash_read_front_chk.sv ====
`timescale 1ns/10ps
`include "sflash_read_regs.vh"

// ----------
// link and fetch checker
// ----------
module sflash_read_front_chk (
  // clock and reset
  input wire               CLK_I,
  input wire               RST_I,
  // link pins
  input wire               CS_N_I,
  input wire               SCK_I,
  input wire               SO_O,
  input wire               SO_OE_O,
  // memory fetch
  input wire               MEM_RD_O,
  input wire [`PAGE_W-1:0] MEM_PAGE_O,
  input wire [`BYTE_W-1:0] MEM_BYTE_O
);
  reg [`PAGE_W-1:0] pg_q;   // page of last fetch
  reg [`BYTE_W-1:0] by_q;   // byte of last fetch
  reg               run_q;  // fetched since select fell
  reg               sck_q;  // sck one cycle back
  reg [3:0]         age_q;  // cycles since sck moved

  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // fetch history; run flag cleared while deselected so each frame starts fresh
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pg_q  <= {`PAGE_W{1'b0}};
      by_q  <= {`BYTE_W{1'b0}};
      run_q <= 1'b0;
      sck_q <= 1'b0;
      age_q <= 4'h0;
    end else begin
      sck_q <= SCK_I;
      age_q <= (SCK_I != sck_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
      run_q <= !CS_N_I && (run_q || MEM_RD_O);
      if (MEM_RD_O) begin
        pg_q <= MEM_PAGE_O;
        by_q <= MEM_BYTE_O;
      end
    end
  end

  chk_oe_after_rise: assert property ($rose(CS_N_I) |-> ##[1:8] !SO_OE_O)
    else $error("output enable stuck after deselect");
  chk_oe_idle_low: assert property (CS_N_I [*8] |-> !SO_OE_O)
    else $error("output enable high while deselected");
  chk_so_low_off: assert property (!SO_OE_O |-> !SO_O)
    else $error("serial output driven while disabled");
  chk_oe_in_frame: assert property ($rose(SO_OE_O) |-> !CS_N_I && !$past(CS_N_I, 8))
    else $error("output enabled outside a frame");
  chk_oe_holds: assert property ($fell(SO_OE_O) |-> CS_N_I && $past(CS_N_I, 2))
    else $error("output dropped while still selected");
  chk_rd_pulse: assert property (MEM_RD_O |=> !MEM_RD_O)
    else $error("fetch strobe longer than one cycle");
  chk_rd_in_frame: assert property (MEM_RD_O |-> !$past(CS_N_I, 8))
    else $error("fetch long after deselect");
  chk_byte_range: assert property (MEM_RD_O |-> MEM_BYTE_O <= `LAST_BYTE)
    else $error("fetch byte beyond page");
  chk_fetch_step: assert property (MEM_RD_O && run_q && by_q != `LAST_BYTE
    |-> MEM_PAGE_O == pg_q && MEM_BYTE_O == by_q + 1'b1) else $error("fetch did not advance by one");
  chk_fetch_wrap: assert property (MEM_RD_O && run_q && by_q == `LAST_BYTE
    |-> MEM_BYTE_O == 0 && (MEM_PAGE_O == pg_q || MEM_PAGE_O == pg_q + 1'b1)) else $error("bad page end wrap");
  chk_so_on_edge: assert property ($changed(SO_O) && SO_OE_O && $past(SO_OE_O)
    |-> age_q >= 4'h1 && age_q <= 4'h6) else $error("output moved without a clock edge");

  cover property (MEM_RD_O && MEM_BYTE_O == `LAST_BYTE);
  cover property (MEM_RD_O && run_q && MEM_PAGE_O != pg_q);
  cover property ($fell(SO_OE_O));
endmodule

bind sflash_read_front sflash_read_front_chk sflash_read_front_chk_i (
  .CLK_I      (CLK_I),
  .RST_I      (RST_I),
  .CS_N_I     (CS_N_I),
  .SCK_I      (SCK_I),
  .SO_O       (SO_O),
  .SO_OE_O    (SO_OE_O),
  .MEM_RD_O   (MEM_RD_O),
  .MEM_PAGE_O (MEM_PAGE_O),
  .MEM_BYTE_O (MEM_BYTE_O)
);

// ==== tb/spi_host_model.sv ====
`timescale 1ns/10ps

// ----------
// spi host, clock mode 0 or 3
// ----------
module spi_host_model (
  // clock
  input  wire        clk_i,
  // link pins
  output reg         cs_n_o,
  output reg         sck_o,
  output reg         si_o,
  input  wire        so_i,
  input  wire        so_oe_i
);
  reg [63:0] rx_q;  // data bits gathered, msb first
  reg        oe_q;  // output enable seen in frame

  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end

  // one bit per period
  // eight clocks a period; so is sampled just before each edge, never at it
  task bit_cyc(input b, input m3, output sr, output sf);
    begin
      if (m3) sck_o <= 1'b0;
      si_o <= b;
      repeat (4) @(posedge clk_i);
      sr = so_i;
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sf = so_i;
      if (!m3) sck_o <= 1'b0;
    end
  endtask

  // select framing
  // data bit k is taken one period after it is launched, in either category
  task frame(input [63:0] hdr, input integer nh, input integer nd, input m3);
    integer i;
    reg     sr;
    reg     sf;
    begin
      oe_q = 1'b0;
      rx_q = 64'h0;
      sck_o <= m3;
      repeat (4) @(posedge clk_i);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      // rising-edge category launches its first bit half a period later, so it runs one period more
      for (i = 0; i < nh + nd + (hdr[63] ? 0 : 1); i = i + 1) begin
        bit_cyc((i < nh) ? hdr[63-i] : ~si_o, m3, sr, sf);
        oe_q = oe_q | so_oe_i;
        if (hdr[63] ? (i >= nh) : (i > nh)) rx_q = {rx_q[62:0], hdr[63] ? sf : sr};
      end
      // released input shows no stale level
      cs_n_o <= 1'b1;
      si_o   <= ~si_o;
      repeat (8) @(posedge clk_i);
    end
  endtask
endmodule

// ==== tb/sflash_read_front_bench.sv ====
`timescale 1ns/10ps
`include "sflash_read_regs.vh"

// ----------
// bench for the serial read front end
// ----------
module sflash_read_front_bench;
  localparam [3:0] DENS = 4'h5;  // arbitrary density code

  reg                CLK_I;
  reg                RST_I;
  reg                BUF_WR_I;
  reg                BUF_SEL_I;
  reg  [`BYTE_W-1:0] BUF_ADDR_I;
  reg  [7:0]         BUF_WDATA_I;
  reg                BUSY_I;
  reg                COMP_MISMATCH_I;
  reg  [7:0]         MEM_RDATA_I;
  wire               CS_N_I;
  wire               SCK_I;
  wire               SI_I;
  wire               SO_O;
  wire               SO_OE_O;
  wire               MEM_RD_O;
  wire [`PAGE_W-1:0] MEM_PAGE_O;
  wire [`BYTE_W-1:0] MEM_BYTE_O;
  integer            err_total;
  integer            n_checks;
  integer            i;
  reg  [9:0]         adr;

  sflash_read_front #(.DENSITY_CODE(DENS)) sflash_read_front_i (
    .CLK_I(CLK_I), .RST_I(RST_I), .CS_N_I(CS_N_I), .SCK_I(SCK_I), .SI_I(SI_I), .SO_O(SO_O), .SO_OE_O(SO_OE_O),
    .MEM_RD_O(MEM_RD_O), .MEM_PAGE_O(MEM_PAGE_O), .MEM_BYTE_O(MEM_BYTE_O), .MEM_RDATA_I(MEM_RDATA_I),
    .BUF_WR_I(BUF_WR_I), .BUF_SEL_I(BUF_SEL_I), .BUF_ADDR_I(BUF_ADDR_I), .BUF_WDATA_I(BUF_WDATA_I),
    .BUSY_I(BUSY_I), .COMP_MISMATCH_I(COMP_MISMATCH_I));

  // undriven output reads as the inverse, not as the last bit
  spi_host_model spi_host_model_i (.clk_i(CLK_I), .cs_n_o(CS_N_I), .sck_o(SCK_I), .si_o(SI_I),
    .so_i(SO_OE_O ? SO_O : ~SO_O), .so_oe_i(SO_OE_O));

  // memory image: page and byte both visible in each byte
  function [7:0] mem_val(input [11:0] p, input [9:0] b);
    mem_val = b[7:0] ^ {p[4:0], b[9:8], 1'b0};
  endfunction

  function [7:0] buf_val(input s, input [9:0] a);
    buf_val = a[7:0] ^ {s, 7'h2A};
  endfunction

  // memory model: one cycle latency, scrambled when not strobed
  always @(posedge CLK_I) begin
    MEM_RDATA_I <= RST_I ? 8'h00 : (MEM_RD_O ? mem_val(MEM_PAGE_O, MEM_BYTE_O) : ~MEM_RDATA_I);
  end

  initial begin
    CLK_I = 1'b0;
    forever #50 CLK_I = ~CLK_I;
  end

  task chk(input string what, input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("Error %s: expected %h, seen %h", what, exp, seen);
      end
    end
  endtask

  task report_and_stop;
    begin
      if (err_total == 0 && n_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // status twice; busy drops between the two bytes
  task stat_case(input [7:0] op, input m3, input cmp);
    begin
      BUSY_I          <= 1'b1;
      COMP_MISMATCH_I <= cmp;
      fork
        spi_host_model_i.frame({op, 56'h0}, 8, 16, m3);
        begin
          repeat (96) @(posedge CLK_I);
          BUSY_I <= 1'b0;
        end
      join
      chk("status busy", spi_host_model_i.rx_q[15:8] & 8'hFC, {1'b0, cmp, DENS, 2'b00});
      chk("status ready", spi_host_model_i.rx_q[7:0] & 8'hFC, {1'b1, cmp, DENS, 2'b00});
    end
  endtask

  // main memory read of n bytes; cont picks array-wide or same-page wrap
  task mem_case(input [7:0] op, input m3, input [11:0] pg, input [9:0] by, input integer n, input cont);
    integer k;
    begin
      spi_host_model_i.frame({op, 2'b11, pg, by, 32'hFFFF_FFFF}, 64, 8 * n, m3);
      chk("memory enable", {7'h0, spi_host_model_i.oe_q}, 8'h01);
      for (k = 0; k < n; k = k + 1) begin
        chk("memory byte", spi_host_model_i.rx_q[8*(n-1-k) +: 8], mem_val(pg, by));
        if (by == `LAST_BYTE) begin
          by = 10'h000;
          pg = pg + {11'h000, cont};
        end else
          by = by + 10'h001;
      end
    end
  endtask

  // buffer read from 526: 526, 527, then wrap to 0
  task buf_case(input [7:0] op, input m3, input s);
    integer k;
    begin
      spi_host_model_i.frame({op, 14'h3FFF, 10'h20E, 8'hFF, 24'h0}, 40, 24, m3);
      for (k = 0; k < 3; k = k + 1) begin
        adr = (k == 2) ? 10'h000 : 10'h20E + 10'(k);
        chk("buffer byte", spi_host_model_i.rx_q[8*(2-k) +: 8], buf_val(s, adr));
      end
    end
  endtask

  // watchdog, well above the six thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge CLK_I);
    err_total = err_total + 1;
    report_and_stop;
  end

  initial begin
    err_total = 0;
    n_checks = 0;
    RST_I = 1'b1;
    BUF_WR_I = 1'b0;
    BUF_SEL_I = 1'b0;
    BUF_ADDR_I = 10'h000;
    BUF_WDATA_I = 8'h00;
    BUSY_I = 1'b0;
    COMP_MISMATCH_I = 1'b0;
    repeat (4) @(posedge CLK_I);
    RST_I <= 1'b0;
    repeat (4) @(posedge CLK_I);
    // five bytes around the wrap point of each buffer, before any memory read
    for (i = 0; i < 10; i = i + 1) begin
      adr = (i % 5 < 3) ? 10'h20D + 10'(i % 5) : 10'(i % 5 - 3);
      BUF_WR_I    <= 1'b1;
      BUF_SEL_I   <= (i >= 5);
      BUF_ADDR_I  <= adr;
      BUF_WDATA_I <= buf_val(i >= 5, adr);
      @(posedge CLK_I);
    end
    BUF_WR_I <= 1'b0;
    stat_case(8'hD7, 1'b0, 1'b0);
    stat_case(8'h57, 1'b1, 1'b1);
    mem_case(8'h68, 1'b0, 12'hFFF, 10'h20E, 3, 1'b1);
    mem_case(8'hE8, 1'b1, 12'h005, 10'h20F, 2, 1'b1);
    mem_case(8'hD2, 1'b0, 12'h007, 10'h20E, 3, 1'b0);
    mem_case(8'h52, 1'b1, 12'hFFF, 10'h20F, 2, 1'b0);
    buf_case(8'h54, 1'b0, 1'b0);
    buf_case(8'hD4, 1'b1, 1'b0);
    buf_case(8'h56, 1'b1, 1'b1);
    buf_case(8'hD6, 1'b0, 1'b1);
    spi_host_model_i.frame({8'h11, 56'hFF_FFFF_FFFF_FFFF}, 64, 16, 1'b0);
    chk("refused enable", {7'h0, spi_host_model_i.oe_q}, 8'h00);
    report_and_stop;
  end
endmodule
